// File: common/pit_defines.svh
/*
  Constants of the peripheral idle timer and trap block: register indices,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from design files; holds definitions only.
*/
// Summary of operation
// R1 - Mouse on serial removes the chosen serial port from parallel/serial monitoring.
// R2 - Parallel/serial port hits reload the 16-bit timer; it counts down each second.
// R3 - Parallel/serial timer runs when enabled; expiry interrupts and sets timer status bit 2.
// R4 - Every expiry also sets bit 0 of the top-level status register.
// R5 - Floppy timer loads from its count when enabled and interrupts on expiry.
// R6 - Floppy decode covers primary ports, plus secondary ports when selected; hits reload.
// R7 - Enabled floppy trap interrupts on a floppy access and sets trap status bit 1.
// R8 - Floppy port select bit: 0 primary only, 1 primary and secondary.
// R9 - Primary disk timer reloads on selected range hits; expiry sets timer status bit 0.
// R10 - Enabled primary disk trap interrupts on access and sets trap status bit 0.
// R11 - Primary partial decode: 0 all of 1F0h-1F7h and 3F6h, 1 writes to 1F6h/1F7h.
// R12 - Secondary disk timer enabled by bit 7; expiry sets status bit 4 of trap status.
// R13 - Bit 6 enables secondary disk trap; access sets trap status bit 5.
// R14 - Secondary partial decode: 0 all of 170h-177h and 376h, 1 writes to 176h/177h.
// R15 - User range timer reloads on matching hits; expiry sets timer status bit 4.
// R16 - Enabled user range trap interrupts on an access within the range.
// R17 - User range hits compare bus address against the 32-bit base register.
// R18 - User control bit 7 selects I/O cycles (0) or memory cycles (1).
// R19 - I/O mode: bit 6 tracks writes, bit 5 tracks reads, bits 4:0 mask A[4:0].
// R20 - Memory mode: bits 6:0 mask A[15:9], A[8:0] always ignored.
// R21 - A set mask bit drops that address bit from the comparison.
// R22 - Each count register holds the 16-bit inactivity period the timer loads.
// R23 - Expiry interrupts only while global power management is set; timers keep counting.
// R24 - Global timer enable gates all timers; disable freezes, re-enable does not reload.
// R25 - Global trap enable gates all traps besides each trap's own enable.
// R26 - Interrupt stays asserted while any timer or trap status bit, or top-level status bit 9, is set until software clears it.
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PIT_IDX_EN1 8'h80
`define PIT_IDX_EN2 8'h81
`define PIT_IDX_EN3 8'h82
`define PIT_IDX_EN4 8'h83
`define PIT_IDX_TSTS 8'h85
`define PIT_IDX_TSTS_RC 8'hf5
`define PIT_IDX_PSTS 8'h86
`define PIT_IDX_PSTS_RC 8'hf6
`define PIT_IDX_MISC 8'h93
`define PIT_IDX_CNT_PRI 8'h98
`define PIT_IDX_CNT_FLP 8'h9a
`define PIT_IDX_CNT_PS 8'h9c
`define PIT_IDX_CNT_USR 8'ha0
`define PIT_IDX_CNT_SEC 8'hac
`define PIT_IDX_USR_BASE 8'hc0
`define PIT_IDX_USR_CTL 8'hcc
`define PIT_IDX_TOP 8'hf0
`define PIT_IDX_TOP_RC 8'hf2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PIT_B_PM 0
`define PIT_B_GTMR 1
`define PIT_B_GTRAP 2
`define PIT_B_PRI 0
`define PIT_B_FLP 1
`define PIT_B_PS 2
`define PIT_B_USR 4
`define PIT_B_SEC_TMR 7
`define PIT_B_SEC_TRAP 6
`define PIT_B_MOUSE_PORT 0
`define PIT_B_MOUSE_SER 1
`define PIT_B_PART_SEC 4
`define PIT_B_PART_PRI 5
`define PIT_B_FLP_SEL 7
`define PIT_S_SEC_TMR 4
`define PIT_S_SEC_TRAP 5
`define PIT_B_USR_MEM 7
`define PIT_B_USR_WR 6
`define PIT_B_USR_RD 5
`define PIT_T_ANY 0
`define PIT_T_UTRAP 9

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define PIT_RST_8 8'h00
`define PIT_RST_16 16'h0000
`define PIT_RST_32 32'h00000000
`define PIT_CLK_HZ 125000000
`define PIT_TIMEBASE_S 1

`endif

// File: common/pit_pkg.sv
/*
  Types shared by the peripheral idle timer and trap block.
  Assumes nothing of its surroundings.
*/
package pit_pkg;
  typedef logic [15:0] pit_count_t;
  typedef enum logic {
    PIT_SPACE_IO = 1'b0,
    PIT_SPACE_MEM = 1'b1
  } pit_space_t;
endpackage

// File: logic/pit_idle_timer.sv
/*
  One 16-bit idle countdown timer with load, reload on access and expiry pulse.
  Assumes a one-cycle timebase tick and a hit pulse from the parent.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pit_defines.svh"
module pit_idle_timer (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_en,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic i_hit,
  input wire pit_pkg::pit_count_t i_load_val,
  output var pit_pkg::pit_count_t o_count,
  output logic o_expire
);
  logic en_d_r;
  logic first_r;

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // The first tick after a load never expires, so a count of 1 wraps silently.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_count <= `PIT_RST_16;
      en_d_r <= 1'b0;
      first_r <= 1'b0;
      o_expire <= 1'b0;
    end else if (i_ce) begin
      en_d_r <= i_en;
      o_expire <= 1'b0;
      if (i_en && !en_d_r) begin
        o_count <= i_load_val; // [R5] [R22]
        first_r <= 1'b1;
      end else if (i_en && i_run) begin // [R3] [R24]
        if (i_hit) begin
          o_count <= i_load_val; // [R2]
          first_r <= 1'b1;
        end else if (i_tick) begin
          o_count <= o_count - 16'h0001; // [R2]
          first_r <= 1'b0;
          o_expire <= (o_count == 16'h0001) && !first_r;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_reload;
    i_ce && i_en && en_d_r && i_run && i_hit |=> o_count == $past(i_load_val);
  endproperty
  a_reload: assert property (p_reload) else $error("hit did not reload the timer"); // [R22]

  property p_freeze;
    i_ce && i_en && en_d_r && !i_run |=> o_count == $past(o_count) && !o_expire;
  endproperty
  a_freeze: assert property (p_freeze) else $error("timer moved while globally disabled"); // [R24]

  property p_expire;
    i_ce && i_en && en_d_r && i_run && !i_hit && i_tick && o_count == 16'h0001 && !first_r
      |=> o_expire && o_count == 16'h0000;
  endproperty
  a_expire: assert property (p_expire) else $error("timer did not expire at zero"); // [R2]
endmodule
`default_nettype wire

// File: logic/pit_top.sv
/*
  Peripheral idle timers and traps with an APB register file.
  Assumes the host bus monitor presents one-cycle cycle pulses synchronous to i_mclk.
*/
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pit_defines.svh"
module pit_top #(
  parameter int unsigned P_TICK_CYCLES = `PIT_CLK_HZ * `PIT_TIMEBASE_S
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cyc_valid,
  input wire logic i_cyc_mem,
  input wire logic i_cyc_write,
  input wire logic [31:0] i_cyc_addr,
  output logic o_smi
);
  logic [2:0] en1_r;
  logic [7:0] en2_r;
  logic [7:0] en3_r;
  logic [7:0] en4_r;
  logic [7:0] misc_r;
  pit_pkg::pit_count_t cnt_pri_r;
  pit_pkg::pit_count_t cnt_flp_r;
  pit_pkg::pit_count_t cnt_ps_r;
  pit_pkg::pit_count_t cnt_usr_r;
  pit_pkg::pit_count_t cnt_sec_r;
  logic [31:0] usr_base_r;
  logic [7:0] usr_ctl_r;
  logic [7:0] tsts_r;
  logic [7:0] psts_r;
  logic [9:0] top_r;
  logic [7:0] tsts_nxt;
  logic [7:0] psts_nxt;
  logic [9:0] top_nxt;
  logic [31:0] tick_cnt_r;
  logic tick_r;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic [7:0] idx;
  logic mapped;
  logic [31:0] rd_val;
  logic setup;
  logic wr_acc;
  logic rd_acc;

  assign idx = i_paddr[9:2];
  assign setup = i_psel && !i_penable;
  assign o_pready = 1'b1;
  assign wr_acc = i_ce && i_psel && i_penable && i_pwrite && mapped;
  assign rd_acc = i_ce && i_psel && i_penable && !i_pwrite && mapped;
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_comb begin
    mapped = (i_paddr[11:10] == 2'b00) && (i_paddr[1:0] == 2'b00);
    rd_val = 32'h00000000;
    if (idx == `PIT_IDX_EN1) begin
      rd_val = {29'h00000000, en1_r};
    end else if (idx == `PIT_IDX_EN2) begin
      rd_val = {24'h000000, en2_r};
    end else if (idx == `PIT_IDX_EN3) begin
      rd_val = {24'h000000, en3_r};
    end else if (idx == `PIT_IDX_EN4) begin
      rd_val = {24'h000000, en4_r};
    end else if (idx == `PIT_IDX_TSTS || idx == `PIT_IDX_TSTS_RC) begin
      rd_val = {24'h000000, tsts_r};
    end else if (idx == `PIT_IDX_PSTS || idx == `PIT_IDX_PSTS_RC) begin
      rd_val = {24'h000000, psts_r};
    end else if (idx == `PIT_IDX_MISC) begin
      rd_val = {24'h000000, misc_r};
    end else if (idx == `PIT_IDX_CNT_PRI) begin
      rd_val = {16'h0000, cnt_pri_r};
    end else if (idx == `PIT_IDX_CNT_FLP) begin
      rd_val = {16'h0000, cnt_flp_r};
    end else if (idx == `PIT_IDX_CNT_PS) begin
      rd_val = {16'h0000, cnt_ps_r};
    end else if (idx == `PIT_IDX_CNT_USR) begin
      rd_val = {16'h0000, cnt_usr_r};
    end else if (idx == `PIT_IDX_CNT_SEC) begin
      rd_val = {16'h0000, cnt_sec_r};
    end else if (idx == `PIT_IDX_USR_BASE) begin
      rd_val = usr_base_r;
    end else if (idx == `PIT_IDX_USR_CTL) begin
      rd_val = {24'h000000, usr_ctl_r};
    end else if (idx == `PIT_IDX_TOP || idx == `PIT_IDX_TOP_RC) begin
      rd_val = {22'h000000, top_r};
    end else begin
      mapped = 1'b0;
    end
  end

  // Read data is captured in the setup phase, so read-to-clear only drops
  // bits that software actually saw.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prdata <= `PIT_RST_32;
    end else if (i_ce && setup && !i_pwrite) begin
      o_prdata <= rd_val;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      en1_r <= 3'h0;
      en2_r <= `PIT_RST_8;
      en3_r <= `PIT_RST_8;
      en4_r <= `PIT_RST_8;
      misc_r <= `PIT_RST_8;
      usr_base_r <= `PIT_RST_32;
      usr_ctl_r <= `PIT_RST_8;
    end else if (wr_acc) begin
      if (idx == `PIT_IDX_EN1) begin
        en1_r <= i_pwdata[2:0];
      end else if (idx == `PIT_IDX_EN2) begin
        en2_r <= i_pwdata[7:0];
      end else if (idx == `PIT_IDX_EN3) begin
        en3_r <= i_pwdata[7:0];
      end else if (idx == `PIT_IDX_EN4) begin
        en4_r <= i_pwdata[7:0];
      end else if (idx == `PIT_IDX_MISC) begin
        misc_r <= i_pwdata[7:0];
      end else if (idx == `PIT_IDX_USR_BASE) begin
        usr_base_r <= i_pwdata; // [R17]
      end else if (idx == `PIT_IDX_USR_CTL) begin
        usr_ctl_r <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_pri_r <= `PIT_RST_16;
      cnt_flp_r <= `PIT_RST_16;
      cnt_ps_r <= `PIT_RST_16;
      cnt_usr_r <= `PIT_RST_16;
      cnt_sec_r <= `PIT_RST_16;
    end else if (wr_acc) begin
      if (idx == `PIT_IDX_CNT_PRI) begin
        cnt_pri_r <= i_pwdata[15:0]; // [R22]
      end else if (idx == `PIT_IDX_CNT_FLP) begin
        cnt_flp_r <= i_pwdata[15:0];
      end else if (idx == `PIT_IDX_CNT_PS) begin
        cnt_ps_r <= i_pwdata[15:0];
      end else if (idx == `PIT_IDX_CNT_USR) begin
        cnt_usr_r <= i_pwdata[15:0];
      end else if (idx == `PIT_IDX_CNT_SEC) begin
        cnt_sec_r <= i_pwdata[15:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Address decode of host cycles (I/O in 16 bits, memory in 32 bits)
  // --------------------------------------------------------------------------
  logic io;
  logic [15:0] a;
  logic ser1;
  logic ser2;
  logic hit_ps;
  logic hit_flp;
  logic hit_pri;
  logic hit_sec;
  logic hit_usr;
  logic [31:0] usr_diff;

  assign io = i_cyc_valid && !i_cyc_mem;
  assign a = i_cyc_addr[15:0];
  assign ser1 = (a & 16'hfff8) == 16'h03f8;
  assign ser2 = (a & 16'hfff8) == 16'h02f8;
  assign usr_diff = i_cyc_addr ^ usr_base_r;

  always_comb begin
    hit_ps = io && (((a & 16'hfff8) == 16'h0378) || ((a & 16'hfff8) == 16'h0278)
      || (ser1 && !(misc_r[`PIT_B_MOUSE_SER] && !misc_r[`PIT_B_MOUSE_PORT])) // [R1]
      || (ser2 && !(misc_r[`PIT_B_MOUSE_SER] && misc_r[`PIT_B_MOUSE_PORT])));
    hit_flp = io && (a == 16'h03f2 || a == 16'h03f4 || a == 16'h03f5 || a == 16'h03f7
      || (misc_r[`PIT_B_FLP_SEL] // [R6] [R8]
      && (a == 16'h0372 || a == 16'h0373 || a == 16'h0375 || a == 16'h0377)));
    if (misc_r[`PIT_B_PART_PRI]) begin // [R11]
      hit_pri = io && i_cyc_write && (a == 16'h01f6 || a == 16'h01f7);
    end else begin
      hit_pri = io && ((a & 16'hfff8) == 16'h01f0 || a == 16'h03f6);
    end
    if (misc_r[`PIT_B_PART_SEC]) begin // [R14]
      hit_sec = io && i_cyc_write && (a == 16'h0176 || a == 16'h0177);
    end else begin
      hit_sec = io && ((a & 16'hfff8) == 16'h0170 || a == 16'h0376);
    end
    if (usr_ctl_r[`PIT_B_USR_MEM] == pit_pkg::PIT_SPACE_MEM) begin // [R18] [R20] [R21]
      hit_usr = i_cyc_valid && i_cyc_mem && (usr_diff[31:16] == 16'h0000)
        && ((usr_diff[15:9] & ~usr_ctl_r[6:0]) == 7'h00);
    end else begin // [R19] [R21]
      hit_usr = io && (usr_diff[15:5] == 11'h000) && ((usr_diff[4:0] & ~usr_ctl_r[4:0]) == 5'h00)
        && (i_cyc_write ? usr_ctl_r[`PIT_B_USR_WR] : usr_ctl_r[`PIT_B_USR_RD]);
    end
  end

  // --------------------------------------------------------------------------
  // Timebase and timers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (i_ce) begin
      tick_r <= (tick_cnt_r == P_TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == P_TICK_CYCLES - 1) ? 32'h00000000 : tick_cnt_r + 32'h00000001;
    end
  end

  logic run;
  logic exp_pri;
  logic exp_flp;
  logic exp_ps;
  logic exp_usr;
  logic exp_sec;
  assign run = en1_r[`PIT_B_GTMR]; // [R24]

  pit_idle_timer u_tmr_pri (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_en(en2_r[`PIT_B_PRI]), .i_run(run), .i_tick(tick_r), .i_hit(hit_pri), // [R9]
    .i_load_val(cnt_pri_r), .o_count(), .o_expire(exp_pri));
  pit_idle_timer u_tmr_flp (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_en(en2_r[`PIT_B_FLP]), .i_run(run), .i_tick(tick_r), .i_hit(hit_flp), // [R5]
    .i_load_val(cnt_flp_r), .o_count(), .o_expire(exp_flp));
  pit_idle_timer u_tmr_ps (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_en(en2_r[`PIT_B_PS]), .i_run(run), .i_tick(tick_r), .i_hit(hit_ps), // [R2]
    .i_load_val(cnt_ps_r), .o_count(), .o_expire(exp_ps));
  pit_idle_timer u_tmr_usr (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_en(en2_r[`PIT_B_USR]), .i_run(run), .i_tick(tick_r), .i_hit(hit_usr), // [R15]
    .i_load_val(cnt_usr_r), .o_count(), .o_expire(exp_usr));
  pit_idle_timer u_tmr_sec (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_en(en4_r[`PIT_B_SEC_TMR]), .i_run(run), .i_tick(tick_r), .i_hit(hit_sec), // [R12]
    .i_load_val(cnt_sec_r), .o_count(), .o_expire(exp_sec));

  // --------------------------------------------------------------------------
  // Status and interrupt
  // --------------------------------------------------------------------------
  logic pm;
  logic gtrap;
  logic [7:0] tsts_set;
  logic [7:0] psts_set;
  logic [7:0] tsts_clr;
  logic [7:0] psts_clr;
  logic [9:0] top_clr;
  logic usr_trap;
  assign pm = en1_r[`PIT_B_PM]; // [R23]
  assign gtrap = en1_r[`PIT_B_GTRAP]; // [R25]
  assign usr_trap = gtrap && en3_r[`PIT_B_USR] && hit_usr; // [R16]

  always_comb begin
    tsts_set = 8'h00;
    psts_set = 8'h00;
    tsts_set[`PIT_B_PRI] = pm && exp_pri; // [R9]
    tsts_set[`PIT_B_FLP] = pm && exp_flp; // [R5]
    tsts_set[`PIT_B_PS] = pm && exp_ps; // [R3]
    tsts_set[`PIT_B_USR] = pm && exp_usr; // [R15]
    psts_set[`PIT_B_PRI] = gtrap && en3_r[`PIT_B_PRI] && hit_pri; // [R10]
    psts_set[`PIT_B_FLP] = gtrap && en3_r[`PIT_B_FLP] && hit_flp; // [R7]
    psts_set[`PIT_B_PS] = gtrap && en3_r[`PIT_B_PS] && hit_ps;
    psts_set[`PIT_S_SEC_TMR] = pm && exp_sec; // [R12]
    psts_set[`PIT_S_SEC_TRAP] = gtrap && en4_r[`PIT_B_SEC_TRAP] && hit_sec; // [R13]
    tsts_clr = (rd_acc && idx == `PIT_IDX_TSTS_RC) ? o_prdata[7:0] : 8'h00;
    psts_clr = (rd_acc && idx == `PIT_IDX_PSTS_RC) ? o_prdata[7:0] : 8'h00;
    top_clr = (rd_acc && idx == `PIT_IDX_TOP_RC) ? o_prdata[9:0] : 10'h000;
    // A new event wins over a clear in the same cycle.
    tsts_nxt = (tsts_r & ~tsts_clr) | tsts_set;
    psts_nxt = (psts_r & ~psts_clr) | psts_set;
    top_nxt = top_r & ~top_clr;
    top_nxt[`PIT_T_ANY] = top_nxt[`PIT_T_ANY] | (|tsts_set) | (|psts_set); // [R4]
    top_nxt[`PIT_T_UTRAP] = top_nxt[`PIT_T_UTRAP] | usr_trap;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tsts_r <= `PIT_RST_8;
      psts_r <= `PIT_RST_8;
      top_r <= 10'h000;
    end else if (i_ce) begin
      tsts_r <= tsts_nxt;
      psts_r <= psts_nxt;
      top_r <= top_nxt;
    end
  end

  assign o_smi = (|tsts_r) || (|psts_r) || top_r[`PIT_T_UTRAP]; // [R26]

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_mouse_excl;
    io && ser1 && misc_r[`PIT_B_MOUSE_SER] && !misc_r[`PIT_B_MOUSE_PORT] |-> !hit_ps;
  endproperty
  a_mouse_excl: assert property (p_mouse_excl) else $error("mouse port still monitored"); // [R1]

  property p_flp_sel;
    io && a == 16'h0372 && !misc_r[`PIT_B_FLP_SEL] |-> !hit_flp;
  endproperty
  a_flp_sel: assert property (p_flp_sel) else $error("secondary floppy decoded while off"); // [R8]

  property p_pri_partial;
    io && misc_r[`PIT_B_PART_PRI] && !i_cyc_write |-> !hit_pri;
  endproperty
  a_pri_partial: assert property (p_pri_partial) else $error("primary read decoded in partial mode"); // [R11]

  property p_sec_full;
    io && !misc_r[`PIT_B_PART_SEC] && a == 16'h0376 |-> hit_sec;
  endproperty
  a_sec_full: assert property (p_sec_full) else $error("secondary 376h not decoded"); // [R14]

  property p_usr_io_rd;
    io && !usr_ctl_r[`PIT_B_USR_MEM] && !i_cyc_write && !usr_ctl_r[`PIT_B_USR_RD] |-> !hit_usr;
  endproperty
  a_usr_io_rd: assert property (p_usr_io_rd) else $error("untracked user read decoded"); // [R19]

  property p_usr_mem;
    i_cyc_valid && i_cyc_mem && usr_ctl_r[`PIT_B_USR_MEM] && usr_diff[31:16] == 16'h0000
      && (usr_diff[15:9] & ~usr_ctl_r[6:0]) == 7'h00 |-> hit_usr;
  endproperty
  a_usr_mem: assert property (p_usr_mem) else $error("user memory range missed"); // [R20]

  property p_par_sts;
    i_ce && pm && exp_ps |=> tsts_r[`PIT_B_PS] && top_r[`PIT_T_ANY] && o_smi;
  endproperty
  a_par_sts: assert property (p_par_sts) else $error("expiry left no status"); // [R3]

  property p_pm_gate;
    i_ce && !pm && !tsts_r[`PIT_B_PS] |=> !tsts_r[`PIT_B_PS];
  endproperty
  a_pm_gate: assert property (p_pm_gate) else $error("status set with power management off"); // [R23]

  property p_trap_gate;
    i_ce && !gtrap && !psts_r[`PIT_B_FLP] |=> !psts_r[`PIT_B_FLP];
  endproperty
  a_trap_gate: assert property (p_trap_gate) else $error("trap fired while globally off"); // [R25]

  property p_flp_trap;
    i_ce && gtrap && en3_r[`PIT_B_FLP] && hit_flp |=> psts_r[`PIT_B_FLP] && o_smi;
  endproperty
  a_flp_trap: assert property (p_flp_trap) else $error("floppy trap missed"); // [R7]

  property p_smi_hold;
    o_smi && !rd_acc |=> o_smi;
  endproperty
  a_smi_hold: assert property (p_smi_hold) else $error("interrupt dropped without a clear"); // [R26]
endmodule
`default_nettype wire

// File: tb/pit_host_model.sv
/*
  Host processor model: issues one I/O or memory bus cycle per call.
  Assumes the caller enters just after a rising edge of i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pit_host_model (
  output logic o_cyc_valid,
  output logic o_cyc_mem,
  output logic o_cyc_write,
  output logic [31:0] o_cyc_addr,
  input wire logic i_mclk
);
  initial begin
    o_cyc_valid = 1'b0;
    o_cyc_mem = 1'b0;
    o_cyc_write = 1'b0;
    o_cyc_addr = 32'h00000000;
  end
  // Qualifiers are inverted after the pulse so a stale address can never look valid.
  task automatic cycle(input logic m, input logic w, input logic [31:0] a);
    o_cyc_valid <= 1'b1;
    o_cyc_mem <= m;
    o_cyc_write <= w;
    o_cyc_addr <= a;
    @(posedge i_mclk);
    o_cyc_valid <= 1'b0;
    o_cyc_mem <= ~m;
    o_cyc_write <= ~w;
    o_cyc_addr <= ~a;
    @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// File: tb/test_pit_top.sv
/*
  Self-checking bench for the idle timer and trap block.
  Assumes the host model file and a short tick parameter of 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pit_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, ca, rd;
  logic pready, pslverr, cv, cm, cw, system_mgmt_interrupt, slv;
  int err_count = 0;
  int total_checks = 0;
  always #4 i_mclk = ~i_mclk;
  pit_top #(.P_TICK_CYCLES(8)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cyc_valid(cv), .i_cyc_mem(cm), .i_cyc_write(cw),
    .i_cyc_addr(ca), .o_smi(system_mgmt_interrupt));
  pit_host_model hm (.o_cyc_valid(cv), .o_cyc_mem(cm), .o_cyc_write(cw), .o_cyc_addr(ca), .i_mclk(i_mclk));
  // ----------------------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------------------
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      summarize();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_regs();
    rchk(8'h81, 32'h0);
    rchk(8'h9c, 32'h0);
    apb(1'b1, 8'h9c, 32'h0000abcd);
    rchk(8'h9c, 32'h0000abcd);
    rchk(8'h70, 32'h0);
    chk({31'h0, slv}, 32'h1);
  endtask
  task automatic t_floppy();
    apb(1'b1, 8'h82, 32'h2);
    hm.cycle(1'b0, 1'b1, 32'h3f2);
    rchk(8'hf6, 32'h0);
    apb(1'b1, 8'h80, 32'h4);
    hm.cycle(1'b0, 1'b0, 32'h372);
    hm.cycle(1'b0, 1'b0, 32'h376);
    rchk(8'hf6, 32'h0);
    apb(1'b1, 8'h93, 32'h80);
    hm.cycle(1'b0, 1'b0, 32'h377);
    chk({31'h0, system_mgmt_interrupt}, 32'h1);
    rchk(8'hf2, 32'h1);
    rchk(8'hf6, 32'h2);
    chk({31'h0, system_mgmt_interrupt}, 32'h0);
  endtask
  task automatic t_disk();
    apb(1'b1, 8'h82, 32'h1);
    apb(1'b1, 8'h83, 32'h40);
    apb(1'b1, 8'h93, 32'h30);
    hm.cycle(1'b0, 1'b0, 32'h1f6);
    hm.cycle(1'b0, 1'b0, 32'h176);
    rchk(8'hf6, 32'h0);
    hm.cycle(1'b0, 1'b1, 32'h1f7);
    hm.cycle(1'b0, 1'b1, 32'h176);
    rchk(8'hf6, 32'h21);
    rchk(8'hf2, 32'h1);
  endtask
  task automatic t_user();
    apb(1'b1, 8'h82, 32'h10);
    apb(1'b1, 8'hc0, 32'h12340000);
    apb(1'b1, 8'hcc, 32'hff);
    hm.cycle(1'b1, 1'b1, 32'h1234fe77);
    rchk(8'hf2, 32'h200);
    hm.cycle(1'b1, 1'b0, 32'h12350000);
    rchk(8'hf2, 32'h0);
    apb(1'b1, 8'hc0, 32'h300);
    apb(1'b1, 8'hcc, 32'h20);
    hm.cycle(1'b0, 1'b1, 32'h300);
    hm.cycle(1'b0, 1'b0, 32'h301);
    rchk(8'hf2, 32'h0);
    apb(1'b1, 8'hcc, 32'h21);
    hm.cycle(1'b0, 1'b0, 32'h301);
    rchk(8'hf2, 32'h200);
    apb(1'b1, 8'h82, 32'h0);
  endtask
  task automatic t_timer();
    int n;
    apb(1'b1, 8'h9c, 32'h2);
    apb(1'b1, 8'h80, 32'h3);
    apb(1'b1, 8'h81, 32'h4);
    // Hits every four cycles beat the eight-cycle tick, so the timer must never reach zero.
    for (n = 0; n < 10; n++) begin
      hm.cycle(1'b0, 1'b0, 32'h2f9);
      repeat (2) @(posedge i_mclk);
    end
    chk({31'h0, system_mgmt_interrupt}, 32'h0);
    apb(1'b1, 8'h93, 32'h2);
    n = 0;
    // Hits on the mouse port must no longer reload, so the timer expires regardless.
    while (system_mgmt_interrupt !== 1'b1 && n < 40) begin
      hm.cycle(1'b0, 1'b0, 32'h3f9);
      n++;
    end
    chk({31'h0, system_mgmt_interrupt}, 32'h1);
    if (n >= 40) summarize();
    rchk(8'hf5, 32'h4);
    rchk(8'hf2, 32'h1);
    apb(1'b1, 8'h80, 32'h1);
    repeat (10) @(posedge i_mclk);
    chk({31'h0, system_mgmt_interrupt}, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    t_regs();
    t_floppy();
    t_disk();
    t_user();
    t_timer();
    summarize();
  end
endmodule
`default_nettype wire
